/* design/ddrc_pkg.sv */
// ddrc_pkg: shared constants and carrier types of the converter data/refresh control.
// assumes one 100 MHz peripheral clock and an APB master with 32-bit data.
package ddrc_pkg;

  // ****************************************
  // register map (index, byte address = index * 4)
  // ****************************************
  localparam logic [5:0] IDX_MODE = 6'h01;
  localparam logic [5:0] IDX_CTRL_C = 6'h02;
  localparam logic [5:0] IDX_TIMING = 6'h04;
  localparam logic [5:0] IDX_FLAGS = 6'h05;
  localparam logic [5:0] IDX_CH0_LO = 6'h18;
  localparam logic [5:0] IDX_CH0_HI = 6'h19;
  localparam logic [5:0] IDX_CH1_LO = 6'h1A;
  localparam logic [5:0] IDX_CH1_HI = 6'h1B;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // ****************************************
  // field layout and codes
  // ****************************************
  localparam int MODE_LSB = 5;
  localparam int ADJ_BIT = 0;
  localparam int CONV_LSB = 4;
  localparam int FLAG_CH0 = 0;
  localparam int FLAG_CH1 = 1;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h2;
  localparam logic [3:0] REFRESH_OFF = 4'hF;
  localparam logic [3:0] REFRESH_MAX_CODE = 4'hC;
  localparam int VALUE_W = 12;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [11:0] VALUE_RESET = 12'h000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_BASE_CYCLES = 16;
  localparam int CNT_W = 17;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ddrc_apb_req_t;

  typedef struct packed {
    logic [1:0] mode_sel;
    logic left_just;
    logic [2:0] conv_interval;
    logic [3:0] refresh_code;
    logic [7:0] temp_byte;
    logic [11:0] ch0_value;
    logic [11:0] ch1_value;
    logic [1:0] empty;
    logic [1:0] refresh;
    logic next_ch;
    logic [31:0] prdata;
    logic pslverr;
  } ddrc_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [3:0] code;
    logic tick;
  } ddrc_timer_t;

endpackage

/* design/ddrc_refresh_timer.sv */
// ddrc_refresh_timer: refresh interval counter, one tick per selected interval.
// assumes run_i is low whenever refresh must not happen.
`timescale 1ns/1ps
module ddrc_refresh_timer
  import ddrc_pkg::*;
#(
  parameter int REFRESH_BASE = REFRESH_BASE_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [3:0] code_i,
  output logic tick_o
);

  ddrc_timer_t t_r;
  ddrc_timer_t t_nxt;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] load;

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    count = CNT_W'(REFRESH_BASE << code_i);
    load = count - CNT_W'(1);
    t_nxt = t_r;
    t_nxt.tick = 1'b0;
    t_nxt.code = code_i;
    // a new code restarts the interval rather than finishing a stale one
    if (!run_i || code_i != t_r.code) begin
      t_nxt.cnt = load;
    end else if (t_r.cnt == '0) begin
      t_nxt.tick = 1'b1;
      t_nxt.cnt = load;
    end else begin
      t_nxt.cnt = t_r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign tick_o = t_r.tick;

  // ****************************************
  // checks
  // ****************************************
  logic [CNT_W-1:0] gap_r;
  logic seen_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (!run_i || code_i != t_r.code) begin
      seen_r <= 1'b0;
      gap_r <= '0;
    end else if (t_r.tick) begin
      seen_r <= 1'b1;
      gap_r <= CNT_W'(1);
    end else begin
      gap_r <= gap_r + CNT_W'(1);
    end
  end

  a_tick_spacing:
  assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (t_r.tick && seen_r && run_i) |-> gap_r == count)
  else $error("refresh ticks not spaced by selected interval");

  a_timer_idle:
  assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !run_i |=> !tick_o)
  else $error("refresh tick while timer idle");

endmodule

/* design/ddrc_core.sv */
// ddrc_core: data registers, empty flags and refresh control of a two-channel converter.
// assumes an APB master on clock_i and an analogue side that pulses conv_take_i.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module ddrc_core
  import ddrc_pkg::*;
#(
  parameter int REFRESH_BASE = REFRESH_BASE_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire ddrc_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] conv_take_i,
  output logic [11:0] ch0_value_o,
  output logic [11:0] ch1_value_o,
  output logic [1:0] dma_req_o,
  output logic [1:0] refresh_o,
  output logic dual_mode_o
);

  ddrc_state_t s_r;
  ddrc_state_t s_nxt;
  logic setup;
  logic wr;
  logic [5:0] idx;
  logic [5:0] idx_q;
  logic refresh_run;
  logic tick;
  logic [1:0] commit;

  // ****************************************
  // bus decode
  // ****************************************
  assign setup = apb_i.psel && !apb_i.penable;
  assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign idx = apb_i.paddr[ADDR_W-1:IDX_LSB];
  assign idx_q = idx;

  // reserved codes are treated as off so a bad write cannot start a runaway refresh
  assign refresh_run = (s_r.mode_sel == MODE_DUAL) && (s_r.refresh_code <= REFRESH_MAX_CODE);

  ddrc_refresh_timer #(
    .REFRESH_BASE(REFRESH_BASE)
  ) u_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .run_i(refresh_run),
    .code_i(s_r.refresh_code),
    .tick_o(tick)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    commit = 2'b00;

    // read data and error are captured in setup, answered in access
    if (setup) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = '0;
      unique case (idx)
        IDX_MODE: begin
          s_nxt.prdata[MODE_LSB +: 2] = s_r.mode_sel;
        end
        IDX_CTRL_C: begin
          s_nxt.prdata[ADJ_BIT] = s_r.left_just;
        end
        IDX_TIMING: begin
          s_nxt.prdata[CONV_LSB +: 3] = s_r.conv_interval;
          s_nxt.prdata[3:0] = s_r.refresh_code;
        end
        IDX_FLAGS: begin
          s_nxt.prdata[FLAG_CH1] = s_r.empty[FLAG_CH1];
          s_nxt.prdata[FLAG_CH0] = s_r.empty[FLAG_CH0];
        end
        IDX_CH0_LO: begin
          s_nxt.prdata[7:0] = s_r.left_just ? {s_r.ch0_value[3:0], 4'h0}
                                            : s_r.ch0_value[7:0];
        end
        IDX_CH0_HI: begin
          s_nxt.prdata[7:0] = s_r.left_just ? s_r.ch0_value[11:4]
                                            : {4'h0, s_r.ch0_value[11:8]};
        end
        IDX_CH1_LO: begin
          s_nxt.prdata[7:0] = s_r.left_just ? {s_r.ch1_value[3:0], 4'h0}
                                            : s_r.ch1_value[7:0];
        end
        IDX_CH1_HI: begin
          s_nxt.prdata[7:0] = s_r.left_just ? s_r.ch1_value[11:4]
                                            : {4'h0, s_r.ch1_value[11:8]};
        end
        default: begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // writes take effect at the access edge; reserved bits are dropped
    if (wr) begin
      unique case (idx_q)
        IDX_MODE: begin
          s_nxt.mode_sel = apb_i.pwdata[MODE_LSB +: 2];
        end
        IDX_CTRL_C: begin
          s_nxt.left_just = apb_i.pwdata[ADJ_BIT];
        end
        IDX_TIMING: begin
          s_nxt.conv_interval = apb_i.pwdata[CONV_LSB +: 3];
          s_nxt.refresh_code = apb_i.pwdata[3:0];
        end
        IDX_FLAGS: begin
          s_nxt.empty = apb_i.pwdata[1:0];
        end
        IDX_CH0_LO, IDX_CH1_LO: begin
          s_nxt.temp_byte = apb_i.pwdata[7:0];
        end
        IDX_CH0_HI: begin
          commit[0] = 1'b1;
          // only the high byte moves the value, so a 12-bit update is atomic
          s_nxt.ch0_value = s_r.left_just ? {apb_i.pwdata[7:0], s_r.temp_byte[7:4]}
                                          : {apb_i.pwdata[3:0], s_r.temp_byte};
        end
        IDX_CH1_HI: begin
          commit[1] = 1'b1;
          s_nxt.ch1_value = s_r.left_just ? {apb_i.pwdata[7:0], s_r.temp_byte[7:4]}
                                          : {apb_i.pwdata[3:0], s_r.temp_byte};
        end
        default: begin
          s_nxt.pslverr = s_r.pslverr;
        end
      endcase
    end

    // a take marks the register empty; a commit in the same cycle
    // leaves it full, since the new value has not been taken yet
    for (int i = 0; i < 2; i++) begin
      if (conv_take_i[i]) begin
        s_nxt.empty[i] = 1'b1;
      end
      if (commit[i]) begin
        s_nxt.empty[i] = 1'b0;
      end
    end

    // refreshes alternate between the two channels
    s_nxt.refresh = 2'b00;
    if (tick && refresh_run) begin
      s_nxt.refresh = s_r.next_ch ? 2'b10 : 2'b01;
      s_nxt.next_ch = !s_r.next_ch;
    end
    if (!refresh_run) begin
      s_nxt.next_ch = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_o = s_r.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = s_r.pslverr && apb_i.psel && apb_i.penable;
  assign ch0_value_o = s_r.ch0_value;
  assign ch1_value_o = s_r.ch1_value;
  assign dma_req_o = s_r.empty;
  assign refresh_o = s_r.refresh;
  assign dual_mode_o = (s_r.mode_sel == MODE_DUAL);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_refresh_dual_only:
  assert property (refresh_o != 2'b00 |-> $past(s_r.mode_sel) == MODE_DUAL)
  else $error("refresh outside dual mode");

  a_refresh_off_code:
  assert property ((s_r.refresh_code == REFRESH_OFF) [*2] |-> refresh_o == 2'b00)
  else $error("refresh while code off");

  a_take_sets_ch1:
  assert property ((conv_take_i[1] && !commit[1]) |=> s_r.empty[1])
  else $error("channel 1 empty flag not set after take");

  a_take_sets_ch0:
  assert property ((conv_take_i[0] && !commit[0]) |=> s_r.empty[0])
  else $error("channel 0 empty flag not set after take");

  a_commit_overwrites:
  assert property ((wr && idx == IDX_CH0_HI && !s_r.left_just) |=>
    ch0_value_o == {$past(apb_i.pwdata[3:0]), $past(s_r.temp_byte)} && !dma_req_o[0])
  else $error("channel 0 commit did not replace value");

  a_low_write_staged:
  assert property ((wr && idx == IDX_CH1_LO) |=> $stable(ch1_value_o))
  else $error("low byte write changed channel 1 value");

  a_flag_fall_cause:
  assert property ($fell(dma_req_o[1]) |->
    $past(wr && (idx == IDX_CH1_HI || idx == IDX_FLAGS)))
  else $error("channel 1 empty flag cleared without write");

  a_right_high_read:
  assert property ((setup && idx == IDX_CH0_HI && !s_r.left_just) |=>
    prdata_o[7:4] == 4'h0 && prdata_o[3:0] == ch0_value_o[11:8])
  else $error("right layout high byte read wrong");

  a_left_low_read:
  assert property ((setup && idx == IDX_CH1_LO && s_r.left_just) |=>
    prdata_o[7:0] == {ch1_value_o[3:0], 4'h0})
  else $error("left layout low byte read wrong");

  a_left_high_write:
  assert property ((wr && idx == IDX_CH1_HI && s_r.left_just) |=>
    ch1_value_o[11:4] == $past(apb_i.pwdata[7:0]))
  else $error("left layout high byte write wrong");

  a_commit_clears_ch0:
  assert property ((wr && idx == IDX_CH0_HI) |=> !dma_req_o[0])
  else $error("channel 0 commit left empty flag set");

  a_commit_clears_ch1:
  assert property ((wr && idx == IDX_CH1_HI) |=> !dma_req_o[1])
  else $error("channel 1 commit left empty flag set");

  a_commit_beats_take:
  assert property ((commit[0] && conv_take_i[0]) |=> !dma_req_o[0])
  else $error("same-cycle take dropped pending channel 0 value");

  a_right_low_read:
  assert property ((setup && idx == IDX_CH0_LO && !s_r.left_just) |=>
    prdata_o[7:0] == ch0_value_o[7:0])
  else $error("right layout low byte read wrong");

  a_left_high_read:
  assert property ((setup && idx == IDX_CH1_HI && s_r.left_just) |=>
    prdata_o[7:0] == ch1_value_o[11:4])
  else $error("left layout high byte read wrong");

  a_flags_read:
  assert property ((setup && idx == IDX_FLAGS) |=> prdata_o[1:0] == $past(s_r.empty))
  else $error("empty flags read wrong");

  // registers are one byte wide, so the upper lanes must never carry stale data
  a_prdata_upper:
  assert property (prdata_o[31:8] == 24'h000000)
  else $error("read data upper bits not zero");

  a_ch0_value_hold:
  assert property (!(wr && idx == IDX_CH0_HI) |=> $stable(ch0_value_o))
  else $error("channel 0 value changed without high byte write");

  a_refresh_one_hot:
  assert property (refresh_o != 2'b11)
  else $error("both channels refreshed at once");

  a_single_no_refresh:
  assert property ((s_r.mode_sel == MODE_SINGLE) [*2] |-> refresh_o == 2'b00)
  else $error("refresh in single channel mode");

  // reserved codes must not run the timer either
  a_reserved_code_off:
  assert property ((s_r.refresh_code > REFRESH_MAX_CODE) [*2] |-> refresh_o == 2'b00)
  else $error("refresh while reserved code set");

endmodule

/* sim/ddrc_conv_model.sv */
// ddrc_conv_model: converter side, takes each pending channel value after a lag.
// assumes dma_req_i low means a committed value waits for the converter.
`timescale 1ns/1ps
module ddrc_conv_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic [3:0] lag_i,
  input wire logic [1:0] dma_req_i,
  output logic [1:0] take_o
);
  // ****************************************
  // take logic
  // ****************************************
  logic [3:0] cnt_r [2];
  // take_o blocks a second pulse while the empty flag is still landing
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      take_o <= 2'h0;
      cnt_r[0] <= 4'h0;
      cnt_r[1] <= 4'h0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        take_o[n] <= 1'b0;
        if (!enable_i || dma_req_i[n] || take_o[n]) begin
          cnt_r[n] <= 4'h0;
        end else if (cnt_r[n] == lag_i) begin
          take_o[n] <= 1'b1;
        end else begin
          cnt_r[n] <= cnt_r[n] + 4'h1;
        end
      end
    end
  end
endmodule

/* sim/tb_top.sv */
// tb_top: self-checking bench of the converter data and refresh control.
// assumes an APB master driven here and the converter model on conv_take_i.
`timescale 1ns/1ps
module tb_top import ddrc_pkg::*;;
  // ****************************************
  // wiring
  // ****************************************
  localparam int BASE = 2;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ddrc_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] take;
  logic [1:0] dma_req;
  logic [1:0] refresh;
  logic [11:0] v0;
  logic [11:0] v1;
  logic dual;
  logic model_en = 1'b0;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int n_checks = 0;

  ddrc_core #(.REFRESH_BASE(BASE)) ddrc_core_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .apb_i(req), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .conv_take_i(take), .ch0_value_o(v0), .ch1_value_o(v1), .dma_req_o(dma_req),
    .refresh_o(refresh), .dual_mode_o(dual));
  ddrc_conv_model ddrc_conv_model_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .enable_i(model_en), .lag_i(4'h5), .dma_req_i(dma_req), .take_o(take));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int i;
    @(posedge clock_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= {idx, 2'b00};
    req.pwdata <= wd;
    @(posedge clock_i);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(name, rd, exp);
  endtask

  // counts edges up to the next refresh pulse
  task automatic gap(output int n, output logic [1:0] b);
    for (n = 1; n <= 20000; n++) begin
      @(posedge clock_i);
      b = refresh;
      if (b !== 2'h0) return;
    end
    fails++;
    end_sim();
  endtask

  task automatic quiet(input string name);
    logic seen;
    seen = 1'b0;
    repeat (4) @(posedge clock_i);
    repeat (100) begin
      @(posedge clock_i);
      if (refresh !== 2'h0) seen = 1'b1;
    end
    chk(name, seen, 1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("dma_req reset", dma_req, 2'h0);
    rdchk("flags reset", IDX_FLAGS, 32'h0);
    rdchk("ch1 high reset", IDX_CH1_HI, 32'h0);
  endtask

  task automatic t_right();
    model_en <= 1'b1;
    bus(1'b1, IDX_CH0_LO, 32'hAB);
    bus(1'b1, IDX_CH0_HI, 32'h0C);
    @(negedge clock_i);
    chk("ch0 right value", v0, 12'hCAB);
    chk("ch0 pending", dma_req[0], 1'b0);
    repeat (12) @(negedge clock_i);
    chk("both empty", dma_req, 2'h3);
    rdchk("flags empty", IDX_FLAGS, 32'h3);
    rdchk("ch0 high right", IDX_CH0_HI, 32'h0C);
    rdchk("ch0 low right", IDX_CH0_LO, 32'hAB);
    model_en <= 1'b0;
  endtask

  task automatic t_left();
    bus(1'b1, IDX_CTRL_C, 32'h1);
    bus(1'b1, IDX_CH1_LO, 32'h50);
    bus(1'b1, IDX_CH1_HI, 32'hA7);
    @(negedge clock_i);
    chk("ch1 left value", v1, 12'hA75);
    bus(1'b1, IDX_CH1_HI, 32'h3C);
    @(negedge clock_i);
    chk("ch1 overwrite", v1, 12'h3C5);
    chk("dma ch1 pending", dma_req, 2'h1);
    rdchk("ch1 low left", IDX_CH1_LO, 32'h50);
    rdchk("ch1 high left", IDX_CH1_HI, 32'h3C);
    bus(1'b1, IDX_CH0_LO, 32'h00);
    @(negedge clock_i);
    chk("ch0 staged only", v0, 12'hCAB);
    bus(1'b1, IDX_CH0_HI, 32'h81);
    @(negedge clock_i);
    chk("ch0 eight bit", v0, 12'h810);
    bus(1'b1, IDX_CTRL_C, 32'h0);
    bus(1'b1, IDX_CH0_HI, 32'h05);
    @(negedge clock_i);
    chk("ch0 back right", v0, 12'h500);
  endtask

  task automatic t_unmapped();
    bus(1'b1, 6'h07, 32'hFF);
    chk("write error", er, 1'b1);
    bus(1'b0, 6'h07, 32'h0);
    chk("read error", er, 1'b1);
    chk("read zero", rd, 32'h0);
  endtask

  task automatic t_refresh();
    int n;
    logic [1:0] b1;
    logic [1:0] b2;
    bus(1'b1, IDX_MODE, 32'h40);
    @(negedge clock_i);
    chk("dual mode", dual, 1'b1);
    for (int c = 0; c <= 12; c++) begin
      bus(1'b1, IDX_TIMING, c);
      gap(n, b1);
      gap(n, b1);
      gap(n, b1);
      chk("refresh interval", n, BASE << c);
      gap(n, b2);
      chk("refresh alternates", b1 ^ b2, 2'h3);
    end
    for (int c = 13; c <= 15; c++) begin
      bus(1'b1, IDX_TIMING, c);
      quiet("refresh off");
    end
    bus(1'b1, IDX_TIMING, 32'h0);
    bus(1'b1, IDX_MODE, 32'h0);
    @(negedge clock_i);
    chk("single mode", dual, 1'b0);
    quiet("single no refresh");
  endtask

  initial begin
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    t_reset();
    t_right();
    t_left();
    t_unmapped();
    t_refresh();
    end_sim();
  end
endmodule
